// [abnenc_core.sv]
// abn quadrature encoder counter with axi4-lite register slave
// Operation
// - each A or B polarity change adds or subtracts the step constant
// - step constant is signed 16.16 fixed point, two's complement
// - decimal mode: low 16 bits are ten-thousandths, 0 to 9999
// - negative constant reverses counting direction
// - negative decimal constant: integer complement minus one, fraction 10000 minus digits
// - continuous N setting clears or latches on every accepted N event
// - single N setting acts on next accepted event, then disarms
// - with AB gating, N accepted only while A and B at set levels
// - N clears position only when clear bit and single or continuous set
// - accepted N event copies position into readable snapshot
// - N clear event sets a status flag
// - position count always readable
// - A, B, N filtered, pulses under three clocks rejected
// - deviation limit with interrupt on motor versus encoder mismatch
//
// The AXI4-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module abnenc_core
  import abnenc_pkg::*;
#(
  parameter int unsigned FILT_N = FILT_LEN
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // encoder inputs
  input  wire logic              enc_a_i,
  input  wire logic              enc_b_i,
  input  wire logic              enc_n_i,
  // motor position for deviation check
  input  wire logic [31:0]       motor_pos_i,
  // axi4-lite write channels
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  // axi4-lite read channels
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  // interrupt
  output logic                   irq_o
);

  typedef struct packed {
    logic [FILT_N-1:0] sa;
    logic [FILT_N-1:0] sb;
    logic [FILT_N-1:0] sn;
    logic              a_f;
    logic              b_f;
    logic              n_f;
    logic [31:0]       pos;
    logic [15:0]       frac;
    logic [31:0]       cnst;
    logic [31:0]       latch;
    logic [31:0]       devlim;
    logic [MODE_W-1:0] mode;
    logic [IRQ_W-1:0]  stat;
    logic [IRQ_W-1:0]  en;
    logic              aw_got;
    logic              w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } abnenc_st_t;

  abnenc_st_t st_r;
  abnenc_st_t st_nxt;

  // filter: output follows only after FILT_N equal samples
  function automatic logic filt(input logic [FILT_N-1:0] sh, input logic cur);
    if (&sh) begin
      filt = 1'b1;
    end else if (~|sh) begin
      filt = 1'b0;
    end else begin
      filt = cur;
    end
  endfunction : filt

  // quadrature decode: {up, down}; forward sequence ab 00,10,11,01
  function automatic logic [1:0] qdir(input logic [1:0] prv, input logic [1:0] cur);
    logic [1:0] fwd;
    logic [1:0] rev;
    unique case (prv)
      2'h0: begin fwd = 2'h2; rev = 2'h1; end
      2'h2: begin fwd = 2'h3; rev = 2'h0; end
      2'h3: begin fwd = 2'h1; rev = 2'h2; end
      2'h1: begin fwd = 2'h0; rev = 2'h3; end
    endcase
    qdir = {cur == fwd, cur == rev};
  endfunction : qdir

  // byte-lane merge of a register write
  function automatic logic [31:0] wmask(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    wmask = r;
  endfunction : wmask

  logic        a_new;
  logic        b_new;
  logic        n_new;
  logic        step_up;
  logic        step_dn;
  logic        n_edge;
  logic        gate_ok;
  logic        armed;
  logic        n_acc;
  logic        wr_fire;
  logic        wr_pos;
  logic        wr_mode;
  logic        dec_mode;
  logic [47:0] pos48;
  logic [47:0] cstep48;
  logic [31:0] dev_diff;
  logic [31:0] dev_abs;
  logic        dev_evt;

  assign a_new   = filt(st_r.sa, st_r.a_f);
  assign b_new   = filt(st_r.sb, st_r.b_f);
  assign n_new   = filt(st_r.sn, st_r.n_f);
  assign {step_up, step_dn} = qdir({st_r.a_f, st_r.b_f}, {a_new, b_new});
  assign n_edge  = (n_new == st_r.mode[MODE_POL_N]) && (st_r.n_f != st_r.mode[MODE_POL_N]);
  assign gate_ok = !st_r.mode[MODE_AB_GATE] ||
                   ((a_new == st_r.mode[MODE_POL_A]) && (b_new == st_r.mode[MODE_POL_B]));
  assign armed   = st_r.mode[MODE_CLR_CONT] || st_r.mode[MODE_CLR_ONCE];
  assign n_acc   = n_edge && gate_ok && armed;
  assign wr_fire = st_r.aw_got && st_r.w_got && !st_r.bvalid;
  assign wr_pos  = wr_fire && (st_r.awaddr == OFS_POS);
  assign wr_mode = wr_fire && (st_r.awaddr == OFS_MODE);
  assign dec_mode = st_r.mode[MODE_DEC];
  assign pos48   = {st_r.pos, st_r.frac};
  assign cstep48 = {{16{st_r.cnst[31]}}, st_r.cnst};
  assign dev_diff = motor_pos_i - st_r.pos;
  assign dev_abs  = dev_diff[31] ? (32'h0000_0000 - dev_diff) : dev_diff;
  assign dev_evt  = (st_r.devlim != 32'h0000_0000) && (dev_abs > st_r.devlim);

  always_comb begin
    logic [16:0] fsum;
    logic        cy;
    logic [31:0] hi;
    logic [31:0] wv;
    fsum   = 17'h0_0000;
    cy     = 1'b0;
    hi     = {{16{st_r.cnst[31]}}, st_r.cnst[31:16]};
    wv     = 32'h0000_0000;
    st_nxt = st_r;

    // input filters
    st_nxt.sa  = {st_r.sa[FILT_N-2:0], enc_a_i};
    st_nxt.sb  = {st_r.sb[FILT_N-2:0], enc_b_i};
    st_nxt.sn  = {st_r.sn[FILT_N-2:0], enc_n_i};
    st_nxt.a_f = a_new;
    st_nxt.b_f = b_new;
    st_nxt.n_f = n_new;

    // position accumulation; a negative constant turns the direction round by itself
    if (step_up || step_dn) begin
      if (!dec_mode) begin
        if (step_up) begin
          {st_nxt.pos, st_nxt.frac} = pos48 + cstep48;
        end else begin
          {st_nxt.pos, st_nxt.frac} = pos48 - cstep48;
        end
      end else if (step_up) begin
        fsum = {1'b0, st_r.frac} + {1'b0, st_r.cnst[15:0]};
        cy   = (fsum >= DEC_BASE);
        if (cy) begin
          fsum = fsum - DEC_BASE;
        end
        st_nxt.frac = fsum[15:0];
        st_nxt.pos  = st_r.pos + hi + {31'h0000_0000, cy};
      end else begin
        fsum = {1'b0, st_r.frac} - {1'b0, st_r.cnst[15:0]};
        cy   = fsum[16];
        if (cy) begin
          fsum = fsum + DEC_BASE;
        end
        st_nxt.frac = fsum[15:0];
        st_nxt.pos  = st_r.pos - hi - {31'h0000_0000, cy};
      end
    end

    // n channel: snapshot, optional clear
    if (n_acc) begin
      st_nxt.latch = st_r.pos;
      if (st_r.mode[MODE_CLR_ENC]) begin
        st_nxt.pos  = 32'h0000_0000;
        st_nxt.frac = 16'h0000;
      end
    end

    // axi write address and data, taken in either order
    if (s_axi_awvalid_i && !st_r.aw_got && !st_r.bvalid) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && !st_r.w_got && !st_r.bvalid) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axi_wdata_i;
      st_nxt.wstrb = s_axi_wstrb_i;
    end
    if (wr_fire) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = RESP_OKAY;
      unique case (st_r.awaddr)
        OFS_MODE: begin
          wv = wmask({24'h00_0000, st_r.mode}, st_r.wdata, st_r.wstrb);
          st_nxt.mode = wv[MODE_W-1:0];
        end
        OFS_POS: begin
          st_nxt.pos  = wmask(st_r.pos, st_r.wdata, st_r.wstrb);
          st_nxt.frac = 16'h0000;
        end
        OFS_CONST:  st_nxt.cnst   = wmask(st_r.cnst, st_r.wdata, st_r.wstrb);
        OFS_DEVLIM: st_nxt.devlim = wmask(st_r.devlim, st_r.wdata, st_r.wstrb);
        OFS_CLR: begin
          if (st_r.wstrb[0]) begin
            st_nxt.stat = st_r.stat & ~st_r.wdata[IRQ_W-1:0];
          end
        end
        OFS_EN: begin
          if (st_r.wstrb[0]) begin
            st_nxt.en = st_r.wdata[IRQ_W-1:0];
          end
        end
        default: st_nxt.bresp = RESP_SLVERR;
      endcase
    end
    if (st_r.bvalid && s_axi_bready_i) begin
      st_nxt.bvalid = 1'b0;
    end

    // single-shot arm drops after its event, after any software write
    if (n_acc && st_r.mode[MODE_CLR_ONCE] && !st_r.mode[MODE_CLR_CONT]) begin
      st_nxt.mode[MODE_CLR_ONCE] = 1'b0;
    end

    // sticky status: a set in the clearing cycle wins
    if (n_acc) begin
      st_nxt.stat[IRQ_N] = 1'b1;
    end
    if (dev_evt) begin
      st_nxt.stat[IRQ_DEV] = 1'b1;
    end

    // axi read
    if (s_axi_arvalid_i && !st_r.rvalid) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = RESP_OKAY;
      unique case (s_axi_araddr_i)
        OFS_MODE:   st_nxt.rdata = {24'h00_0000, st_r.mode};
        OFS_POS:    st_nxt.rdata = st_r.pos;
        OFS_CONST:  st_nxt.rdata = st_r.cnst;
        OFS_LATCH:  st_nxt.rdata = st_r.latch;
        OFS_STAT:   st_nxt.rdata = {30'h0000_0000, st_r.stat};
        OFS_CLR:    st_nxt.rdata = 32'h0000_0000;
        OFS_EN:     st_nxt.rdata = {30'h0000_0000, st_r.en};
        OFS_DEVLIM: st_nxt.rdata = st_r.devlim;
        default: begin
          st_nxt.rdata = 32'h0000_0000;
          st_nxt.rresp = RESP_SLVERR;
        end
      endcase
    end else if (st_r.rvalid && s_axi_rready_i) begin
      st_nxt.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r        <= '0;
      st_r.cnst   <= CONST_RST;
      st_r.mode   <= MODE_RST;
      st_r.devlim <= DEVLIM_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_awready_o = !st_r.aw_got && !st_r.bvalid;
  assign s_axi_wready_o  = !st_r.w_got && !st_r.bvalid;
  assign s_axi_bvalid_o  = st_r.bvalid;
  assign s_axi_bresp_o   = st_r.bresp;
  assign s_axi_arready_o = !st_r.rvalid;
  assign s_axi_rvalid_o  = st_r.rvalid;
  assign s_axi_rdata_o   = st_r.rdata;
  assign s_axi_rresp_o   = st_r.rresp;
  assign irq_o           = |(st_r.stat & st_r.en);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic frac_ok;
  assign frac_ok = (st_r.frac < DEC_BASE[15:0]);

  chk_filter_delay: assert property ($changed(st_r.a_f) |->
      ($past(enc_a_i, 2) == st_r.a_f) && ($past(enc_a_i, 3) == st_r.a_f) && ($past(enc_a_i, 4) == st_r.a_f))
    else $error("filtered A changed without three stable samples");

  chk_step_add: assert property ((step_up && !dec_mode && !n_acc && !wr_pos) |=>
      (pos48 - $past(pos48)) == $past(cstep48))
    else $error("forward step did not add the constant");

  chk_step_sub: assert property ((step_dn && !dec_mode && !n_acc && !wr_pos) |=>
      ($past(pos48) - pos48) == $past(cstep48))
    else $error("reverse step did not subtract the constant");

  chk_dec_fraction: assert property ((dec_mode && frac_ok && (st_r.cnst[15:0] < DEC_BASE[15:0]) && !wr_mode) |=>
      frac_ok)
    else $error("decimal fraction left range 0 to 9999");

  chk_once_disarm: assert property ((n_acc && st_r.mode[MODE_CLR_ONCE] && !st_r.mode[MODE_CLR_CONT]) |=>
      !st_r.mode[MODE_CLR_ONCE] && !armed)
    else $error("single-shot N did not disarm");

  chk_cont_armed: assert property ((n_acc && st_r.mode[MODE_CLR_CONT] && !wr_mode) |=>
      st_r.mode[MODE_CLR_CONT] && armed)
    else $error("continuous N disarmed itself");

  chk_latch_copy: assert property (n_acc |=> st_r.latch == $past(st_r.pos))
    else $error("snapshot does not hold position at N event");

  chk_clear_pos: assert property ((n_acc && st_r.mode[MODE_CLR_ENC] && !wr_pos) |=>
      (st_r.pos == 32'h0000_0000) && (st_r.frac == 16'h0000))
    else $error("position not cleared on N event");

  chk_unarmed_idle: assert property ((n_edge && !armed) |=> $stable(st_r.latch))
    else $error("unarmed N event changed the snapshot");

  chk_n_gating: assert property ((n_acc && st_r.mode[MODE_AB_GATE]) |=>
      (st_r.a_f == $past(st_r.mode[MODE_POL_A])) && (st_r.b_f == $past(st_r.mode[MODE_POL_B])))
    else $error("N accepted outside gating levels");

  chk_status_set: assert property (n_acc |=> st_r.stat[IRQ_N] ##1 (st_r.stat[IRQ_N] || $past(wr_fire)))
    else $error("N event status flag not set");

endmodule : abnenc_core

`default_nettype wire

// [abnenc_pkg.sv]
// constants for the abn quadrature encoder counter
package abnenc_pkg;

  // register byte offsets
  localparam int unsigned ADDR_W     = 8;
  localparam logic [7:0]  OFS_MODE   = 8'h00;
  localparam logic [7:0]  OFS_POS    = 8'h04;
  localparam logic [7:0]  OFS_CONST  = 8'h08;
  localparam logic [7:0]  OFS_LATCH  = 8'h0C;
  localparam logic [7:0]  OFS_STAT   = 8'h10;
  localparam logic [7:0]  OFS_CLR    = 8'h14;
  localparam logic [7:0]  OFS_EN     = 8'h18;
  localparam logic [7:0]  OFS_DEVLIM = 8'h1C;

  // encoder_mode_config field positions
  localparam int unsigned MODE_W        = 8;
  localparam int unsigned MODE_POL_A    = 0;
  localparam int unsigned MODE_POL_B    = 1;
  localparam int unsigned MODE_POL_N    = 2;
  localparam int unsigned MODE_AB_GATE  = 3;
  localparam int unsigned MODE_CLR_CONT = 4;
  localparam int unsigned MODE_CLR_ONCE = 5;
  localparam int unsigned MODE_CLR_ENC  = 6;
  localparam int unsigned MODE_DEC      = 7;

  // interrupt status bit positions
  localparam int unsigned IRQ_W   = 2;
  localparam int unsigned IRQ_N   = 0;
  localparam int unsigned IRQ_DEV = 1;

  // reset values
  localparam logic [7:0]  MODE_RST   = 8'h00;
  localparam logic [31:0] CONST_RST  = 32'h0001_0000;
  localparam logic [31:0] DEVLIM_RST = 32'h0000_0000;

  // decimal fraction base and input filter length in clocks
  localparam logic [16:0] DEC_BASE = 17'h0_2710;
  localparam int unsigned FILT_LEN = 3;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : abnenc_pkg

// [abnenc_enc_model.sv]
// behavioural incremental encoder driving A, B and N
`timescale 1ns/1ps
`default_nettype none

module abnenc_enc_model (
  // clock
  input  wire logic clk_i,
  // bench commands
  input  wire logic step_i,
  input  wire logic dir_i,
  input  wire logic spike_i,
  input  wire logic index_i,
  // encoder lines
  output logic      enc_a_o = 1'b0,
  output logic      enc_b_o = 1'b0,
  output logic      enc_n_o = 1'b0
);
  logic [1:0] phase_r = 2'h0;

  // forward order 00, 10, 11, 01; a line only moves when the bench asks, spaced well apart
  always @(posedge clk_i) begin
    if (step_i) phase_r <= dir_i ? phase_r - 2'h1 : phase_r + 2'h1;
    enc_a_o <= (phase_r[0] ^ phase_r[1]) ^ spike_i;
    enc_b_o <= phase_r[1];
    enc_n_o <= index_i;
  end
endmodule : abnenc_enc_model
`default_nettype wire

// [tb_abnenc_core.sv]
// register-level testbench for the quadrature encoder counter
`timescale 1ns/1ps
`default_nettype none

module tb_abnenc_core;
  import abnenc_pkg::*;
  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              enc_a, enc_b, enc_n;
  logic              step = 1'b0, dir = 1'b0, spike = 1'b0, index = 1'b0;
  logic [31:0]       motor_pos = 32'h0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0]       wdata = 32'h0, rdata;
  logic [3:0]        wstrb = 4'hF;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]        bresp, rresp;
  int                n_mismatch = 0;
  int                checked = 0;
  int                cycles = 0;

  initial forever #5 clk_i = ~clk_i;

  abnenc_enc_model i_abnenc_enc_model (.clk_i(clk_i), .step_i(step), .dir_i(dir), .spike_i(spike),
    .index_i(index), .enc_a_o(enc_a), .enc_b_o(enc_b), .enc_n_o(enc_n));

  abnenc_core i_abnenc_core (.clk_i(clk_i), .rst_i(rst_i), .enc_a_i(enc_a), .enc_b_i(enc_b), .enc_n_i(enc_n),
    .motor_pos_i(motor_pos), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .irq_o(irq));

  task automatic close_out();
    if (n_mismatch == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch = n_mismatch + 1;
      close_out();
    end
  end

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked = checked + 1;
    if (g !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  // irq is combinational from registers, so it is judged away from the edge that launches it
  task automatic cmp_irq(input logic e);
    @(negedge clk_i);
    cmp("irq", {31'h0, e}, {31'h0, irq});
    @(posedge clk_i);
  endtask : cmp_irq

  // handshakes are judged at the falling edge, acted on after the next rising edge
  task automatic wc(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic ha, hw, hb;
    awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    hb = 1'b0;
    while (!hb) begin
      @(negedge clk_i);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid && bready;
      if (hb) cmp("bresp", {30'h0, er}, {30'h0, bresp});
      @(posedge clk_i);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end
  endtask : wc

  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ha, hr;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    hr = 1'b0;
    while (!hr) begin
      @(negedge clk_i);
      ha = arvalid && arready;
      hr = rvalid && rready;
      if (hr) cmp("rdata", e, rdata);
      if (hr) cmp("rresp", {30'h0, er}, {30'h0, rresp});
      @(posedge clk_i);
      if (ha) arvalid <= 1'b0;
    end
  endtask : rc

  // steps spaced eight clocks apart, far below one third of the clock rate
  task automatic steps(input logic d, input int n);
    repeat (n) begin
      step <= 1'b1; dir <= d;
      @(posedge clk_i);
      step <= 1'b0;
      repeat (7) @(posedge clk_i);
    end
  endtask : steps

  task automatic npulse();
    index <= 1'b1;
    repeat (8) @(posedge clk_i);
    index <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask : npulse

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rc(OFS_MODE, 32'h0000_0000, RESP_OKAY);
    rc(OFS_CONST, 32'h0001_0000, RESP_OKAY);
    rc(OFS_POS, 32'h0000_0000, RESP_OKAY);
    rc(OFS_LATCH, 32'h0000_0000, RESP_OKAY);
    rc(OFS_STAT, 32'h0000_0000, RESP_OKAY);
    rc(OFS_EN, 32'h0000_0000, RESP_OKAY);
    rc(8'h20, 32'h0000_0000, RESP_SLVERR);
    wc(OFS_LATCH, 32'h0000_0055, 4'hF, RESP_SLVERR);
    wc(8'h24, 32'h0000_0055, 4'hF, RESP_SLVERR);
    wc(OFS_DEVLIM, 32'hFFFF_FFFF, 4'h1, RESP_OKAY);
    rc(OFS_DEVLIM, 32'h0000_00FF, RESP_OKAY);
    wc(OFS_DEVLIM, 32'h0000_0000, 4'hF, RESP_OKAY);
    steps(1'b0, 5);
    rc(OFS_POS, 32'h0000_0005, RESP_OKAY);
    steps(1'b1, 7);
    rc(OFS_POS, 32'hFFFF_FFFE, RESP_OKAY);
    spike <= 1'b1;
    repeat (2) @(posedge clk_i);
    spike <= 1'b0;
    repeat (8) @(posedge clk_i);
    rc(OFS_POS, 32'hFFFF_FFFE, RESP_OKAY);
    wc(OFS_CONST, 32'hFFFF_0000, 4'hF, RESP_OKAY);
    wc(OFS_POS, 32'h0000_0000, 4'hF, RESP_OKAY);
    steps(1'b0, 3);
    rc(OFS_POS, 32'hFFFF_FFFD, RESP_OKAY);
    wc(OFS_CONST, 32'h0000_8000, 4'hF, RESP_OKAY);
    wc(OFS_POS, 32'h0000_0000, 4'hF, RESP_OKAY);
    steps(1'b0, 3);
    rc(OFS_POS, 32'h0000_0001, RESP_OKAY);
    wc(OFS_MODE, 32'h0000_0080, 4'hF, RESP_OKAY);
    wc(OFS_CONST, 32'h0000_1388, 4'hF, RESP_OKAY);
    wc(OFS_POS, 32'h0000_0000, 4'hF, RESP_OKAY);
    steps(1'b0, 3);
    rc(OFS_POS, 32'h0000_0001, RESP_OKAY);
    steps(1'b1, 4);
    rc(OFS_POS, 32'hFFFF_FFFF, RESP_OKAY);
    wc(OFS_CONST, 32'hFFE6_0FA0, 4'hF, RESP_OKAY);
    wc(OFS_POS, 32'h0000_0000, 4'hF, RESP_OKAY);
    steps(1'b0, 1);
    rc(OFS_POS, 32'hFFFF_FFE6, RESP_OKAY);
    wc(OFS_MODE, 32'h0000_0000, 4'hF, RESP_OKAY);
    wc(OFS_CONST, 32'h0001_0000, 4'hF, RESP_OKAY);
    wc(OFS_POS, 32'h0000_0000, 4'hF, RESP_OKAY);
    steps(1'b0, 2);
    wc(OFS_EN, 32'h0000_0001, 4'hF, RESP_OKAY);
    // single shot: clear once, then disarm
    wc(OFS_MODE, 32'h0000_0064, 4'hF, RESP_OKAY);
    npulse();
    rc(OFS_POS, 32'h0000_0000, RESP_OKAY);
    rc(OFS_LATCH, 32'h0000_0002, RESP_OKAY);
    rc(OFS_STAT, 32'h0000_0001, RESP_OKAY);
    cmp_irq(1'b1);
    rc(OFS_MODE, 32'h0000_0044, RESP_OKAY);
    steps(1'b0, 1);
    npulse();
    rc(OFS_POS, 32'h0000_0001, RESP_OKAY);
    wc(OFS_CLR, 32'h0000_0001, 4'hF, RESP_OKAY);
    rc(OFS_STAT, 32'h0000_0000, RESP_OKAY);
    cmp_irq(1'b0);
    // continuous latch without clear, then with clear twice
    wc(OFS_MODE, 32'h0000_0014, 4'hF, RESP_OKAY);
    npulse();
    rc(OFS_POS, 32'h0000_0001, RESP_OKAY);
    rc(OFS_LATCH, 32'h0000_0001, RESP_OKAY);
    wc(OFS_MODE, 32'h0000_0054, 4'hF, RESP_OKAY);
    npulse();
    rc(OFS_POS, 32'h0000_0000, RESP_OKAY);
    steps(1'b0, 1);
    npulse();
    rc(OFS_POS, 32'h0000_0000, RESP_OKAY);
    rc(OFS_MODE, 32'h0000_0054, RESP_OKAY);
    // gating on A and B both high; lines now at 00, two forward steps reach 11
    wc(OFS_MODE, 32'h0000_005F, 4'hF, RESP_OKAY);
    wc(OFS_CLR, 32'h0000_0001, 4'hF, RESP_OKAY);
    wc(OFS_POS, 32'h0000_0007, 4'hF, RESP_OKAY);
    npulse();
    rc(OFS_POS, 32'h0000_0007, RESP_OKAY);
    rc(OFS_STAT, 32'h0000_0000, RESP_OKAY);
    steps(1'b0, 2);
    npulse();
    rc(OFS_POS, 32'h0000_0000, RESP_OKAY);
    rc(OFS_LATCH, 32'h0000_0009, RESP_OKAY);
    // deviation flag, masked then enabled
    wc(OFS_EN, 32'h0000_0000, 4'hF, RESP_OKAY);
    wc(OFS_DEVLIM, 32'h0000_0005, 4'hF, RESP_OKAY);
    motor_pos <= 32'h0000_0064;
    repeat (4) @(posedge clk_i);
    rc(OFS_STAT, 32'h0000_0003, RESP_OKAY);
    cmp_irq(1'b0);
    wc(OFS_EN, 32'h0000_0003, 4'hF, RESP_OKAY);
    cmp_irq(1'b1);
    motor_pos <= 32'h0000_0000;
    wc(OFS_CLR, 32'h0000_0003, 4'hF, RESP_OKAY);
    rc(OFS_STAT, 32'h0000_0000, RESP_OKAY);
    cmp_irq(1'b0);
    close_out();
  end
endmodule : tb_abnenc_core
`default_nettype wire
